/* core/bpf_regs.svh */
// Register offsets, field positions, reset values and counts of the block.
// ---------------------------------------------------------------------
// Notes on behaviour
// - Detection flags counts below low limit.
// - Detection flags counts above high limit.
// - Responsivity below low percent is bad; floor 50.
// - Responsivity above high percent of mean is bad.
// - Pause run when bad percentage reaches threshold.
// - Sample frame averages configured frame count.
// - Judge pixels only with detection on, during runs.
// - Replacement substitutes preceding good pixel value.
// - Separate readable count per failing criterion.
// - Readable total of bad pixels, latest run.
// - One-point run makes offset only.
// - Two-point run makes offset and gain.
// - Internal source drives flag; external needs operator.
// - Four presets; actions target the selected one.
// - Auto save writes result to flash.
// - Load fills preset; save stores preset.
// - Abort stops a running correction.
// - Full window corrects all, else window only.
// ---------------------------------------------------------------------
`ifndef BPF_REGS_SVH
`define BPF_REGS_SVH
`define BPF_OFF_CTRL 8'h00
`define BPF_OFF_CFG 8'h04
`define BPF_OFF_LIMIT 8'h08
`define BPF_OFF_RESP 8'h0c
`define BPF_OFF_PAUSE 8'h10
`define BPF_OFF_WIN 8'h14
`define BPF_OFF_STAT 8'h18
`define BPF_OFF_CNT 8'h1c
`define BPF_OFF_TOTAL 8'h20
`define BPF_CTRL_START 0
`define BPF_CTRL_ABORT 1
`define BPF_CTRL_CONT 2
`define BPF_CTRL_SAVE 3
`define BPF_CTRL_LOAD 4
`define BPF_CTRL_DEL 5
`define BPF_CFG_PRESET 1:0
`define BPF_CFG_TWO 2
`define BPF_CFG_EXT 3
`define BPF_CFG_DET 4
`define BPF_CFG_REPL 5
`define BPF_CFG_ASAVE 6
`define BPF_CFG_FULL 7
`define BPF_CFG_FLOG 10:8
`define BPF_CFG_SLOT 15:12
`define BPF_LIM_LO 13:0
`define BPF_LIM_HI 29:16
`define BPF_RESP_LO 7:0
`define BPF_RESP_HI 15:8
`define BPF_PAUSE_F 15:0
`define BPF_WIN_FIRST 5:0
`define BPF_WIN_LAST 13:8
`define BPF_RST_LO 14'h01f4
`define BPF_RST_HI 14'h36b0
`define BPF_RST_RLO 8'h32
`define BPF_RST_RHI 8'h96
`define BPF_RST_FLOG 3'h4
`define BPF_RST_PAUSE 16'h01f4
`define BPF_RST_WLAST 6'h3f
`define BPF_FLOG_MAX 3'h4
`define BPF_DIV_STEPS 5'h1a
`define BPF_UNITY_GAIN 15'h1000
`define BPF_GAIN_MAX 15'h7fff
`define BPF_PCT_SCALE 24'h002710
`define BPF_HUNDRED 24'h000064
`define BPF_LAST_PIX 6'h3f
`endif

/* core/bpf_pkg.sv */
// Types shared by the flat-field correction block.
`default_nettype none
package bpf_pkg;
	// Sequencer states of a correction run and of storage moves.
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_WAIT = 4'h1, ST_COLL = 4'h2, ST_MEAN = 4'h3,
		ST_MDIV = 4'h4, ST_EVAL = 4'h5, ST_EDIV = 4'h6, ST_ENXT = 4'h7,
		ST_PAUSE = 4'h8, ST_NVSV = 4'h9, ST_NVLD = 4'ha, ST_NVDL = 4'hb
	} bpf_state_type;
	// Storage operations.
	typedef enum logic [1:0] {
		NV_READ = 2'h0, NV_WRITE = 2'h1, NV_ERASE = 2'h2
	} bpf_nvop_type;
	// Software configuration.
	typedef struct packed {
		logic [1:0] preset;
		logic two;
		logic ext;
		logic det;
		logic repl;
		logic asave;
		logic full;
		logic [2:0] flog;
		logic [3:0] slot;
		logic [13:0] lo;
		logic [13:0] hi;
		logic [7:0] rlo;
		logic [7:0] rhi;
		logic [15:0] pause;
		logic [5:0] wfirst;
		logic [5:0] wlast;
	} bpf_cfg_type;
	// Incoming detector pixel.
	typedef struct packed {
		logic valid;
		logic sof;
		logic [13:0] data;
	} bpf_pix_type;
	// Corrected pixel.
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} bpf_pout_type;
	// Request to the non-volatile store.
	typedef struct packed {
		logic req;
		bpf_nvop_type op;
		logic [3:0] slot;
		logic [5:0] addr;
		logic [31:0] wdata;
	} bpf_nv_type;
	// Bad pixel counters.
	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] hi;
		logic [7:0] rlo;
		logic [7:0] rhi;
		logic [7:0] tot;
	} bpf_cnt_type;
	// Whole state of the core.
	typedef struct packed {
		bpf_state_type st;
		bpf_cfg_type cfg;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic level;
		logic armed;
		logic [4:0] frame;
		logic [5:0] pix;
		logic [5:0] walk;
		logic [19:0] sum;
		logic [6:0] cnt;
		logic [13:0] mean1;
		logic [13:0] meanr;
		logic [25:0] dnum;
		logic [15:0] rem;
		logic [15:0] den;
		logic [4:0] step;
		bpf_cnt_type bad;
		logic pdone;
		logic flag_in;
		logic flag_hot;
		bpf_nv_type nv;
		bpf_pout_type pout;
		logic [15:0] last_good;
	} bpf_st_type;
endpackage
`default_nettype wire

/* core/bpf_core.sv */
// Flat-field correction and defect pixel substitution core with APB slave.
//
// Design decisions made here: the APB register port and the address map.
`include "bpf_regs.svh"
`default_nettype none
module bpf_core (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire bpf_pkg::bpf_pix_type I_PIX,
	output bpf_pkg::bpf_pout_type O_PIX,
	output logic O_FLAG_IN,
	output logic O_FLAG_HOT,
	output bpf_pkg::bpf_nv_type O_NV,
	input wire logic I_NV_ACK,
	input wire logic [31:0] I_NV_RDATA
);
	import bpf_pkg::*;

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	bpf_st_type s_q; // Registered state.
	bpf_st_type s_d; // Next state.
	logic [17:0] acc_m [64]; // Frame accumulators.
	logic [13:0] lvl_m [64]; // First level averages.
	logic [31:0] corr_m [256]; // Per preset {bad, gain, offset}.
	logic acc_we, lvl_we, corr_we; // Memory write strobes.
	logic [5:0] acc_wa; // Accumulator write address.
	logic [17:0] acc_wd; // Accumulator write data.
	logic [13:0] lvl_wd; // Level write data.
	logic [7:0] corr_wa; // Correction write address.
	logic [31:0] corr_wd; // Correction write data.
	logic setup, wr_ok; // Bus phases.
	logic c_start, c_abort, c_cont, c_save, c_load, c_del; // Commands.
	logic [31:0] rd; // Read data of the addressed register.
	logic mapped; // Address hits a register.
	logic [5:0] pidx; // Index of the incoming pixel.
	logic [4:0] fr; // Frame number of the incoming pixel.
	logic [31:0] cw; // Correction word of the incoming pixel.
	logic signed [17:0] dif; // Pixel less offset.
	logic signed [33:0] prod; // Scaled pixel.
	logic [15:0] corr_px; // Clipped corrected pixel.
	logic [13:0] lv, avg2, resp, v; // Walk values.
	logic b_lo, b_hi, b_rl, b_rh, bad; // Criteria of the walked pixel.
	logic [16:0] r17; // Divider partial remainder.
	logic ge; // Divider quotient bit.
	logic [7:0] tot_n; // Total after this pixel.
	logic [19:0] sum_n; // Sum after this pixel.
	logic [6:0] cnt_n; // Pixels in use after this pixel.
	logic [14:0] gain; // Gain of the walked pixel.

	// Pixel takes part in a run when full window or inside the window.
	function automatic logic in_use(input bpf_cfg_type c,
		input logic [5:0] i);
		return c.full | ((i >= c.wfirst) && (i <= c.wlast));
	endfunction

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	// One process computes all next values and memory writes.
	always_comb begin
		s_d = s_q;
		acc_we = 1'b0;
		lvl_we = 1'b0;
		corr_we = 1'b0;
		corr_wa = {s_q.cfg.preset, s_q.walk};
		corr_wd = 32'h0;
		lvl_wd = 14'h0;
		// The bus is answered one cycle after setup, with no wait state.
		setup = I_PSEL & ~I_PENABLE;
		wr_ok = I_PSEL & I_PENABLE & s_q.pready & I_PWRITE;
		c_start = wr_ok && I_PADDR == `BPF_OFF_CTRL && I_PWDATA[`BPF_CTRL_START];
		c_abort = wr_ok && I_PADDR == `BPF_OFF_CTRL && I_PWDATA[`BPF_CTRL_ABORT];
		c_cont = wr_ok && I_PADDR == `BPF_OFF_CTRL && I_PWDATA[`BPF_CTRL_CONT];
		c_save = wr_ok && I_PADDR == `BPF_OFF_CTRL && I_PWDATA[`BPF_CTRL_SAVE];
		c_load = wr_ok && I_PADDR == `BPF_OFF_CTRL && I_PWDATA[`BPF_CTRL_LOAD];
		c_del = wr_ok && I_PADDR == `BPF_OFF_CTRL && I_PWDATA[`BPF_CTRL_DEL];
		mapped = 1'b1;
		case (I_PADDR)
			`BPF_OFF_CTRL: rd = 32'h0;
			`BPF_OFF_CFG: rd = {16'h0, s_q.cfg.slot, 1'b0, s_q.cfg.flog,
				s_q.cfg.full, s_q.cfg.asave, s_q.cfg.repl, s_q.cfg.det,
				s_q.cfg.ext, s_q.cfg.two, s_q.cfg.preset};
			`BPF_OFF_LIMIT: rd = {2'h0, s_q.cfg.hi, 2'h0, s_q.cfg.lo};
			`BPF_OFF_RESP: rd = {16'h0, s_q.cfg.rhi, s_q.cfg.rlo};
			`BPF_OFF_PAUSE: rd = {16'h0, s_q.cfg.pause};
			`BPF_OFF_WIN: rd = {18'h0, s_q.cfg.wlast, 2'h0, s_q.cfg.wfirst};
			`BPF_OFF_STAT: rd = {26'h0, s_q.st == ST_PAUSE,
				s_q.st != ST_IDLE, s_q.st};
			`BPF_OFF_CNT: rd = {s_q.bad.rhi, s_q.bad.rlo, s_q.bad.hi,
				s_q.bad.lo};
			`BPF_OFF_TOTAL: rd = {24'h0, s_q.bad.tot};
			default: begin
				rd = 32'h0;
				mapped = 1'b0;
			end
		endcase
		s_d.pready = setup & ~s_q.pready;
		s_d.pslverr = setup & ~s_q.pready & ~mapped;
		s_d.prdata = (setup & ~I_PWRITE) ? rd : 32'h0;
		// Configuration only changes between runs.
		if (wr_ok && s_q.st == ST_IDLE) begin
			case (I_PADDR)
				`BPF_OFF_CFG: begin
					s_d.cfg.preset = I_PWDATA[`BPF_CFG_PRESET];
					s_d.cfg.two = I_PWDATA[`BPF_CFG_TWO];
					s_d.cfg.ext = I_PWDATA[`BPF_CFG_EXT];
					s_d.cfg.det = I_PWDATA[`BPF_CFG_DET];
					s_d.cfg.repl = I_PWDATA[`BPF_CFG_REPL];
					s_d.cfg.asave = I_PWDATA[`BPF_CFG_ASAVE];
					s_d.cfg.full = I_PWDATA[`BPF_CFG_FULL];
					s_d.cfg.flog = (I_PWDATA[`BPF_CFG_FLOG] > `BPF_FLOG_MAX) ?
						`BPF_FLOG_MAX : I_PWDATA[`BPF_CFG_FLOG];
					s_d.cfg.slot = I_PWDATA[`BPF_CFG_SLOT];
				end
				`BPF_OFF_LIMIT: begin
					s_d.cfg.lo = I_PWDATA[`BPF_LIM_LO];
					s_d.cfg.hi = I_PWDATA[`BPF_LIM_HI];
				end
				`BPF_OFF_RESP: begin
					// The low percentage never goes under its floor.
					s_d.cfg.rlo = (I_PWDATA[`BPF_RESP_LO] < `BPF_RST_RLO) ?
						`BPF_RST_RLO : I_PWDATA[`BPF_RESP_LO];
					s_d.cfg.rhi = I_PWDATA[`BPF_RESP_HI];
				end
				`BPF_OFF_PAUSE: s_d.cfg.pause = I_PWDATA[`BPF_PAUSE_F];
				`BPF_OFF_WIN: begin
					s_d.cfg.wfirst = I_PWDATA[`BPF_WIN_FIRST];
					s_d.cfg.wlast = I_PWDATA[`BPF_WIN_LAST];
				end
				default: begin
				end
			endcase
		end

		// Pixel path: offset, gain, then substitution of bad pixels.
		pidx = I_PIX.sof ? 6'h0 : s_q.pix;
		cw = corr_m[{s_q.cfg.preset, pidx}];
		dif = $signed({4'h0, I_PIX.data}) - $signed({{2{cw[15]}}, cw[15:0]});
		prod = (34'(dif) * $signed({19'h0, cw[30:16]})) >>> 12;
		corr_px = prod[33] ? 16'h0 : (|prod[32:16]) ? 16'hffff : prod[15:0];
		s_d.pout.valid = I_PIX.valid;
		if (I_PIX.valid) begin
			s_d.pix = 6'(pidx + 6'h1);
			if (s_q.cfg.repl && cw[31]) begin
				s_d.pout.data = s_q.last_good;
			end else begin
				s_d.pout.data = corr_px;
				s_d.last_good = corr_px;
			end
		end

		// Frame accumulation for the sample frame.
		fr = I_PIX.sof ? (s_q.armed ? 5'(s_q.frame + 5'h1) : 5'h0) :
			s_q.frame;
		acc_wa = pidx;
		acc_wd = 18'(((fr == 5'h0) ? 18'h0 : acc_m[pidx]) + I_PIX.data);

		// Walk values and classification of the walked pixel.
		lv = lvl_m[s_q.walk];
		avg2 = 14'(acc_m[s_q.walk] >> s_q.cfg.flog);
		resp = (avg2 > lv) ? 14'(avg2 - lv) : 14'h0;
		v = s_q.level ? resp : avg2;
		sum_n = in_use(s_q.cfg, s_q.walk) ? 20'(s_q.sum + v) : s_q.sum;
		cnt_n = in_use(s_q.cfg, s_q.walk) ? 7'(s_q.cnt + 7'h1) : s_q.cnt;
		b_lo = s_q.cfg.det && lv < s_q.cfg.lo;
		b_hi = s_q.cfg.det && lv > s_q.cfg.hi;
		b_rl = s_q.cfg.det && s_q.cfg.two && (24'(resp) * `BPF_HUNDRED <
			24'(s_q.meanr) * 24'(s_q.cfg.rlo));
		b_rh = s_q.cfg.det && s_q.cfg.two && (24'(resp) * `BPF_HUNDRED >
			24'(s_q.meanr) * 24'(s_q.cfg.rhi));
		bad = b_lo | b_hi | b_rl | b_rh;
		tot_n = 8'(s_q.bad.tot + {7'h0, bad});
		gain = !s_q.cfg.two ? `BPF_UNITY_GAIN :
			(|s_q.dnum[25:15]) ? `BPF_GAIN_MAX : s_q.dnum[14:0];
		r17 = {s_q.rem, s_q.dnum[25]};
		ge = r17 >= {1'b0, s_q.den};
		lvl_wd = avg2;

		// Sequencer.
		case (s_q.st)
			ST_IDLE: begin
				if (c_start) begin
					s_d.level = 1'b0;
					s_d.armed = 1'b0;
					s_d.pdone = 1'b0;
					s_d.flag_in = ~s_q.cfg.ext;
					s_d.st = s_q.cfg.ext ? ST_WAIT : ST_COLL;
				end else if (c_save || c_load || c_del) begin
					s_d.walk = 6'h0;
					s_d.st = c_save ? ST_NVSV : c_load ? ST_NVLD : ST_NVDL;
				end
			end
			ST_WAIT: begin
				// The operator sets the blackbody, then continues.
				if (c_cont) begin
					s_d.st = ST_COLL;
				end
			end
			ST_COLL: begin
				if (I_PIX.valid && I_PIX.sof && s_q.armed &&
					fr == 5'(6'h1 << s_q.cfg.flog)) begin
					s_d.st = ST_MEAN;
					s_d.walk = 6'h0;
					s_d.sum = 20'h0;
					s_d.cnt = 7'h0;
				end else if (I_PIX.valid && (I_PIX.sof || s_q.armed)) begin
					s_d.armed = 1'b1;
					s_d.frame = fr;
					acc_we = 1'b1;
				end
			end
			ST_MEAN: begin
				lvl_we = ~s_q.level;
				s_d.sum = sum_n;
				s_d.cnt = cnt_n;
				s_d.walk = 6'(s_q.walk + 6'h1);
				if (s_q.walk == `BPF_LAST_PIX) begin
					s_d.dnum = 26'(sum_n);
					s_d.rem = 16'h0;
					s_d.den = (cnt_n == 7'h0) ? 16'h1 : 16'(cnt_n);
					s_d.step = `BPF_DIV_STEPS;
					s_d.st = ST_MDIV;
				end
			end
			ST_MDIV, ST_EDIV: begin
				if (s_q.step != 5'h0) begin
					// One restoring division step per cycle.
					s_d.rem = ge ? 16'(r17 - {1'b0, s_q.den}) : r17[15:0];
					s_d.dnum = {s_q.dnum[24:0], ge};
					s_d.step = 5'(s_q.step - 5'h1);
				end else if (s_q.st == ST_MDIV) begin
					if (!s_q.level) begin
						s_d.mean1 = s_q.dnum[13:0];
					end else begin
						s_d.meanr = s_q.dnum[13:0];
					end
					if (!s_q.level && s_q.cfg.two) begin
						s_d.level = 1'b1;
						s_d.armed = 1'b0;
						s_d.flag_hot = ~s_q.cfg.ext;
						s_d.st = s_q.cfg.ext ? ST_WAIT : ST_COLL;
					end else begin
						s_d.flag_in = 1'b0;
						s_d.flag_hot = 1'b0;
						s_d.bad = '0;
						s_d.walk = 6'h0;
						s_d.st = ST_EVAL;
					end
				end else begin
					corr_we = 1'b1;
					corr_wd = {bad, gain, 16'(lv - s_q.mean1)};
					s_d.bad.lo = 8'(s_q.bad.lo + {7'h0, b_lo});
					s_d.bad.hi = 8'(s_q.bad.hi + {7'h0, b_hi});
					s_d.bad.rlo = 8'(s_q.bad.rlo + {7'h0, b_rl});
					s_d.bad.rhi = 8'(s_q.bad.rhi + {7'h0, b_rh});
					s_d.bad.tot = tot_n;
					s_d.st = ST_ENXT;
					if (bad && !s_q.pdone && 24'(tot_n) * `BPF_PCT_SCALE >=
						24'(s_q.cfg.pause) * 24'(s_q.cnt)) begin
						s_d.pdone = 1'b1;
						s_d.st = ST_PAUSE;
					end
				end
			end
			ST_EVAL: begin
				s_d.rem = 16'h0;
				s_d.dnum = {s_q.meanr, 12'h0};
				s_d.den = 16'(resp);
				// Only two-point runs need the gain division.
				s_d.step = s_q.cfg.two ? `BPF_DIV_STEPS : 5'h0;
				s_d.st = in_use(s_q.cfg, s_q.walk) ? ST_EDIV : ST_ENXT;
			end
			ST_ENXT: begin
				s_d.walk = 6'(s_q.walk + 6'h1);
				s_d.st = ST_EVAL;
				if (s_q.walk == `BPF_LAST_PIX) begin
					s_d.walk = 6'h0;
					s_d.st = s_q.cfg.asave ? ST_NVSV : ST_IDLE;
				end
			end
			ST_PAUSE: begin
				if (c_cont) begin
					s_d.st = ST_ENXT;
				end
			end
			ST_NVSV, ST_NVLD, ST_NVDL: begin
				// One request per word (one for the whole slot on delete), dropped on its acknowledge.
				s_d.nv.slot = s_q.cfg.slot;
				s_d.nv.addr = s_q.walk;
				s_d.nv.op = (s_q.st == ST_NVSV) ? NV_WRITE :
					(s_q.st == ST_NVLD) ? NV_READ : NV_ERASE;
				s_d.nv.wdata = corr_m[corr_wa];
				if (!s_q.nv.req) begin
					s_d.nv.req = 1'b1;
				end else if (I_NV_ACK) begin
					s_d.nv.req = 1'b0;
					corr_we = (s_q.st == ST_NVLD);
					corr_wd = I_NV_RDATA;
					s_d.walk = 6'(s_q.walk + 6'h1);
					if (s_q.walk == `BPF_LAST_PIX || s_q.st == ST_NVDL) begin
						s_d.st = ST_IDLE;
					end
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase

		// Abort ends a run at once; storage moves finish on their own.
		if (c_abort && s_q.st != ST_IDLE && s_q.st != ST_NVSV &&
			s_q.st != ST_NVLD && s_q.st != ST_NVDL) begin
			s_d.st = ST_IDLE;
			s_d.flag_in = 1'b0;
			s_d.flag_hot = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// State register with documented defaults after reset.
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			s_q <= '0;
			s_q.cfg.lo <= `BPF_RST_LO;
			s_q.cfg.hi <= `BPF_RST_HI;
			s_q.cfg.rlo <= `BPF_RST_RLO;
			s_q.cfg.rhi <= `BPF_RST_RHI;
			s_q.cfg.flog <= `BPF_RST_FLOG;
			s_q.cfg.pause <= `BPF_RST_PAUSE;
			s_q.cfg.wlast <= `BPF_RST_WLAST;
		end else begin
			s_q <= s_d;
		end
	end

	// Pixel memories hold data only, so they carry no reset.
	always_ff @(posedge I_CORE_CLK) begin
		if (acc_we) begin
			acc_m[acc_wa] <= acc_wd;
		end
		if (lvl_we) begin
			lvl_m[s_q.walk] <= lvl_wd;
		end
		if (corr_we) begin
			corr_m[corr_wa] <= corr_wd;
		end
	end

	// Outputs come straight from the state register.
	assign O_PRDATA = s_q.prdata;
	assign O_PREADY = s_q.pready;
	assign O_PSLVERR = s_q.pslverr;
	assign O_PIX = s_q.pout;
	assign O_FLAG_IN = s_q.flag_in;
	assign O_FLAG_HOT = s_q.flag_hot;
	assign O_NV = s_q.nv;
endmodule
`default_nettype wire

/* verification/bpf_checker.sv */
// Port-level assertions for the flat-field correction core.
`default_nettype none
module bpf_checker (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire bpf_pkg::bpf_pix_type I_PIX,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	input wire bpf_pkg::bpf_pout_type O_PIX,
	input wire logic O_FLAG_IN,
	input wire bpf_pkg::bpf_nv_type O_NV,
	input wire logic I_NV_ACK
);
	import bpf_pkg::*;
	// ------------------------------------------------------------
	// Bus, pixel and storage timing.
	// ------------------------------------------------------------
	// All checks share the core clock and are idle in reset.
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_RST_N);
	a_ready_setup: assert property (
		I_PSEL && !I_PENABLE |=> O_PREADY) else $error("No ready.");
	a_ready_once: assert property (
		O_PREADY |=> !O_PREADY) else $error("Long ready.");
	a_err_ready: assert property (
		O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
		else $error("Bad error reply.");
	a_rdata_idle: assert property (
		!O_PREADY |-> O_PRDATA == 32'h0) else $error("Stray data.");
	a_pix_next: assert property (
		I_PIX.valid |=> O_PIX.valid) else $error("Pixel lost.");
	a_pix_quiet: assert property (
		!I_PIX.valid |=> !O_PIX.valid) else $error("Extra pixel.");
	a_nv_hold: assert property (
		O_NV.req && !I_NV_ACK |=> O_NV.req && $stable(O_NV))
		else $error("Store request moved.");
	a_nv_drop: assert property (
		O_NV.req && I_NV_ACK |=> !O_NV.req) else $error("Req held.");
	// Main scenarios reached.
	c_nv_done: cover property (O_NV.req && I_NV_ACK);
	c_err: cover property (O_PSLVERR);
	c_flag: cover property (O_FLAG_IN);
endmodule
bind bpf_core bpf_checker u_bpf_checker (.I_CORE_CLK(I_CORE_CLK),
	.I_RST_N(I_RST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
	.I_PIX(I_PIX), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
	.O_PSLVERR(O_PSLVERR), .O_PIX(O_PIX), .O_FLAG_IN(O_FLAG_IN),
	.O_NV(O_NV), .I_NV_ACK(I_NV_ACK));
`default_nettype wire

/* verification/bpf_nv_model.sv */
// Behavioural non-volatile store answering the core's requests.
`default_nettype none
module bpf_nv_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire bpf_pkg::bpf_nv_type nv,
	output logic ack,
	output logic [31:0] rdata
);
	import bpf_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [16][64]; // Sixteen slots of one word a pixel.
	int wcount = 0; // Words written so far.
	bit slow = 0; // Alternates prompt and late answers.
	// ------------------------------------------------------------
	// Request handling.
	// ------------------------------------------------------------
	// Slot 5 holds a neutral correction: zero offset, unity gain.
	initial begin
		for (int a = 0; a < 64; a++) begin
			mem[5][a] = 32'h10000000;
		end
		ack = 0;
		rdata = 32'h0;
		forever begin
			@(posedge clk);
			if (rst_n === 1 && nv.req === 1) begin
				repeat (slow ? 3 : 0) @(posedge clk);
				slow = !slow;
				ack <= 1;
				rdata <= mem[nv.slot][nv.addr];
				if (nv.op == NV_WRITE) begin
					mem[nv.slot][nv.addr] = nv.wdata;
					wcount++;
				end
				if (nv.op == NV_ERASE) begin
					for (int a = 0; a < 64; a++) begin
						mem[nv.slot][a] = 32'h0;
					end
				end
				@(posedge clk);
				ack <= 0;
				// Data is not held after the answer.
				rdata <= ~rdata;
			end
		end
	end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the flat-field correction core.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bpf_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic flag_in, flag_hot, nv_ack;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, nv_rdata;
	bpf_pix_type pix;
	bpf_pout_type pout;
	bpf_nv_type nv;
	int bad_count = 0, num_checks = 0, nframes = 0, mode = 0;
	logic [32:0] rq [$]; // Expected {error, data} of reads.
	logic [15:0] pq [$]; // Expected corrected pixels.
	logic [13:0] cal [64]; // Calibration scene.
	logic [31:0] seed = 32'hc7e8;
	logic [15:0] mean;
	bit want = 0, flag_seen = 0, hot_seen = 0;
	bpf_core u_bpf_core (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .I_PIX(pix), .O_PIX(pout),
		.O_FLAG_IN(flag_in), .O_FLAG_HOT(flag_hot), .O_NV(nv),
		.I_NV_ACK(nv_ack), .I_NV_RDATA(nv_rdata));
	bpf_nv_model u_bpf_nv_model (.clk(clk), .rst_n(rst_n), .nv(nv),
		.ack(nv_ack), .rdata(nv_rdata));
	// ------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Replaced pixels take the preceding good output.
	function automatic logic [15:0] exp_rep(input int i);
		int j;
		j = (i >= 10 && i <= 12) ? 9 : (i == 20 || i == 21) ? 19 : i;
		return mean + 16'(j);
	endfunction
	task automatic check(input string nm, input logic [32:0] e, g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic fail(input string nm);
		check(nm, 33'h1, 33'h0);
		final_report();
	endtask
	// One APB transfer; the request stands until ready is seen.
	task automatic apb(input bit w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		// Ready is taken at the rising edge, as it stood in that cycle.
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1 && n < 20);
		if (n >= 20) fail("apb ready");
		r = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1, a, d, r);
	endtask
	task automatic rd_exp(input logic [7:0] a, input logic [32:0] e);
		logic [31:0] r;
		rq.push_back(e);
		want = 1;
		apb(0, a, 32'h0, r);
		want = 0;
	endtask
	// Poll the status word until the sequencer shows state s.
	task automatic wait_st(input logic [3:0] s);
		logic [31:0] r;
		for (int n = 0; n < 3000; n++) begin
			apb(0, 8'h18, 32'h0, r);
			if (r[3:0] === s) break;
		end
		check("state", 33'(s), 33'(r[3:0]));
		if (r[3:0] !== s) final_report();
	endtask
	// Stream frames with mode m and drain the scoreboard.
	task automatic frames(input int m);
		int f;
		f = nframes;
		mode = m;
		for (int n = 0; n < 1000 && nframes < f + 2; n++) @(posedge clk);
		mode = 0;
		for (int n = 0; n < 1000 && nframes < f + 3; n++) @(posedge clk);
		if (nframes < f + 3) fail("frames");
		check("queue", 33'h0, 33'(pq.size()));
	endtask
	// ------------------------------------------------------------
	// Pixel stream, monitors and watchdog.
	// ------------------------------------------------------------
	initial begin
		pix = '0;
		@(posedge rst_n);
		forever begin
			automatic int m = mode;
			for (int i = 0; i < 64; i++) begin
				@(posedge clk);
				// The hot flag doubles the scene: responsivity equals it.
				pix <= '{1'b1, i == 0, m ? cal[i] + 14'(i) :
					(flag_hot === 1'b1) ? 14'(cal[i] << 1) : cal[i]};
				if (m == 1) pq.push_back(exp_rep(i));
				if (m == 2) pq.push_back(16'(cal[i]) + 16'(i));
			end
			@(posedge clk);
			pix <= '0;
			@(posedge clk);
			nframes++;
		end
	end
	always @(negedge clk) begin
		if (pready === 1 && want && rq.size() > 0) begin
			check("prdata", rq.pop_front(), {pslverr, prdata});
		end
		if (pout.valid === 1 && pq.size() > 0) begin
			check("pixel", 33'(pq.pop_front()), 33'(pout.data));
		end
		if (flag_in === 1) flag_seen = 1;
		if (flag_hot === 1) hot_seen = 1;
	end
	initial begin
		repeat (100000) @(posedge clk);
		fail("run time");
	end
	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial begin
		int s;
		s = 0;
		rst_n = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 8'h0;
		pwdata = 32'h0;
		// Random scene with three dark and two hot defects.
		for (int i = 0; i < 64; i++) begin
			seed = lfsr(seed);
			cal[i] = 14'd400 + 14'(seed[7:0]);
		end
		cal[10] = 14'd50;
		cal[11] = 14'd50;
		cal[12] = 14'd50;
		cal[20] = 14'd2000;
		cal[21] = 14'd2000;
		for (int i = 0; i < 64; i++) s += cal[i];
		mean = 16'(s / 64);
		repeat (6) @(posedge clk);
		rst_n <= 1;
		rd_exp(8'h04, 33'h400);
		rd_exp(8'h08, 33'h36b001f4);
		rd_exp(8'h0c, 33'h9632);
		rd_exp(8'h10, 33'h1f4);
		rd_exp(8'h14, 33'h3f00);
		rd_exp(8'h1c, 33'h0);
		rd_exp(8'h20, 33'h0);
		rd_exp(8'h40, 33'h100000000);
		wr(8'h0c, 32'h9620);
		rd_exp(8'h0c, 33'h9632);
		// External source waits for the operator; abort it there.
		wr(8'h04, 32'h8);
		wr(8'h00, 32'h1);
		wait_st(4'h1);
		check("flag ext", 33'h0, 33'(flag_in));
		wr(8'h00, 32'h2);
		wait_st(4'h0);
		// Internal one-point run with detection and auto save.
		wr(8'h08, 32'h03e80064);
		wr(8'h04, 32'h3050);
		wr(8'h00, 32'h1);
		wait_st(4'h8);
		check("flag int", 33'h1, 33'(flag_seen));
		wr(8'h00, 32'h4);
		wait_st(4'h0);
		rd_exp(8'h1c, 33'h0203);
		rd_exp(8'h20, 33'h5);
		check("saved", 33'd64, 33'(u_bpf_nv_model.wcount));
		check("word", {2'b0, 15'h1000, 16'(cal[5]) - mean},
			33'(u_bpf_nv_model.mem[3][5]));
		check("bad", 33'h1, 33'(u_bpf_nv_model.mem[3][10][31]));
		// Internal two-point run into preset 1; defects fail both tests.
		wr(8'h0c, 32'hc832);
		wr(8'h04, 32'h15);
		wr(8'h00, 32'h1);
		wait_st(4'h8);
		check("flag hot", 33'h1, 33'(hot_seen));
		wr(8'h00, 32'h4);
		wait_st(4'h0);
		rd_exp(8'h1c, 33'h02030203);
		rd_exp(8'h20, 33'h5);
		wr(8'h04, 32'h3070);
		frames(1);
		// Load a neutral correction, then delete its slot.
		wr(8'h04, 32'h5000);
		wr(8'h00, 32'h10);
		wait_st(4'h0);
		frames(2);
		wr(8'h00, 32'h20);
		wait_st(4'h0);
		check("erase", 33'h0, 33'(u_bpf_nv_model.mem[5][0]));
		final_report();
	end
endmodule
`default_nettype wire
